// ---- src/axis_pkg.sv ----
// Purpose: Shared constants and types for the single-axis JOG / restore / stop block
// Assumes: 100 MHz pclk, 32-bit APB data, one aligned word per register
// Notes: All offsets are byte addresses; status codes are 16-bit two's complement
package axis_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS = 1_000_000;
	localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned ABS_TIMEOUT_MS = 100;
	localparam int unsigned ABS_TIMEOUT_CYC = ABS_TIMEOUT_MS * CYC_PER_MS;
	// Data limits
	localparam logic [31:0] JOG_SPEED_MAX = 32'h00030D40;
	localparam logic [15:0] RAMP_MS_MAX = 16'h7FFF;
	localparam logic [31:0] SPEED_LIMIT_RST = 32'h00030D40;
	localparam logic [3:0] ABS_LAST_XFER = 4'hF;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_JOG_SPEED = 8'h04;
	localparam logic [7:0] OFS_JOG_ACC = 8'h08;
	localparam logic [7:0] OFS_JOG_DEC = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_OP_ERR_CODE = 8'h14;
	localparam logic [7:0] OFS_AXIS_ERR_CODE = 8'h18;
	localparam logic [7:0] OFS_AXIS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_FEED = 8'h20;
	localparam logic [7:0] OFS_SPEED_LIMIT = 8'h24;
	localparam logic [7:0] OFS_CUR_SPEED = 8'h28;
	// Control bit positions
	localparam int CTL_ENABLE = 0;
	localparam int CTL_DIR = 1;
	localparam int CTL_JOG = 2;
	localparam int CTL_ABS = 3;
	localparam int CTL_STOP = 4;
	localparam int CTL_OPBAD = 5;
	localparam int CTL_W = 6;
	// Flag bit positions
	localparam int FLG_BUSY = 0;
	localparam int FLG_DONE = 1;
	localparam int FLG_AXERR = 2;
	localparam int FLG_OPERR = 3;
	localparam int FLG_SERVO = 4;
	// Error codes
	localparam logic [15:0] OPERR_OPERAND = 16'h1005;
	localparam logic [15:0] OPERR_NOT_USED = 16'h1014;
	localparam logic [15:0] AXERR_STOP_AT_START = 16'h044E;
	localparam logic [15:0] AXERR_DATA_RANGE = 16'h03E8;
	localparam logic [15:0] AXERR_ABS_TIMEOUT = 16'h07D0;
	// Axis operation status values
	localparam logic [15:0] ST_STANDBY = 16'h0000;
	localparam logic [15:0] ST_STOPPED = 16'h0001;
	localparam logic [15:0] ST_ERROR = 16'hFFFF;
	localparam logic [15:0] ST_JOG_RUN = 16'h0003;
	localparam logic [15:0] ST_STOP_DEC = 16'h0007;
	localparam logic [15:0] ST_JOG_DEC = 16'h0008;
	localparam logic [15:0] ST_ABS = 16'h000A;
	// Axis sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_JOG_RUN = 3'b001,
		S_JOG_DEC = 3'b010,
		S_STOP_DEC = 3'b011,
		S_ABS_REQ = 3'b100,
		S_ABS_REL = 3'b101
	} axis_state_t;
endpackage : axis_pkg

// ---- src/motion_if.sv ----
// Purpose: Speed command path between the axis sequencer, ramp and pulse generator
// Assumes: All members are synchronous to pclk
// Notes: Speeds in pulses per second, ramp time in ms
`timescale 1ns/1ps
interface motion_if;
	logic [31:0] target; // Speed to ramp toward
	logic [31:0] ref_speed; // Full-scale speed of one ramp
	logic [15:0] ramp_ms; // Ramp time for full scale
	logic [31:0] speed; // Present output speed
	logic step; // One output pulse issued
	modport ctrl (output target, output ref_speed, output ramp_ms, input speed, input step);
	modport ramp (input target, input ref_speed, input ramp_ms, output speed);
	modport gen (input speed, output step);
endinterface : motion_if

// ---- src/speed_ramp.sv ----
// Purpose: Linear speed ramp toward a target over a time given in ms
// Assumes: Target and ramp time held stable while a ramp runs
// Notes: At most one pulse/s of change per clock; a zero ramp time jumps to the target at once
`timescale 1ns/1ps
module speed_ramp (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Speed path
	motion_if.ramp m
);
	logic [47:0] acc_q; // Time accumulator
	logic [47:0] acc_d;
	logic [47:0] thresh; // Ramp time in cycles
	logic [31:0] speed_q;
	logic [31:0] speed_d;
	logic tick; // One unit of speed change is due

	assign thresh = 48'(m.ramp_ms) * 48'(axis_pkg::CYC_PER_MS);
	assign tick = (acc_q + 48'(m.ref_speed)) >= thresh;
	assign m.speed = speed_q;

	// Accumulate so that full scale is crossed in ramp_ms
	always_comb begin
		acc_d = acc_q + 48'(m.ref_speed);
		speed_d = speed_q;
		if (speed_q == m.target) begin
			acc_d = '0;
		end else if (m.ramp_ms == 16'h0000) begin
			speed_d = m.target; // Zero time jumps at once
			acc_d = '0;
		end else if (tick) begin
			acc_d = acc_q + 48'(m.ref_speed) - thresh;
			speed_d = (speed_q < m.target) ? speed_q + 32'h00000001 : speed_q - 32'h00000001;
		end
	end

	// State update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= '0;
			speed_q <= '0;
		end else begin
			acc_q <= acc_d;
			speed_q <= speed_d;
		end
	end
endmodule : speed_ramp

// ---- src/pulse_gen.sv ----
// Purpose: Turn a speed in pulses/s into single-cycle pulses
// Assumes: Speed below the clock rate
// Notes: Phase accumulator, so pulse spacing jitters by one clock
`timescale 1ns/1ps
module pulse_gen (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Speed path
	motion_if.gen m,
	// Pulse pin
	output logic pulse_out
);
	logic [31:0] phase_q; // Phase accumulator
	logic [31:0] phase_sum;
	logic wrap; // Phase passed one second

	assign phase_sum = phase_q + m.speed;
	assign wrap = phase_sum >= axis_pkg::CLK_HZ;
	assign m.step = pulse_out;

	// Accumulate and emit a pulse on each wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= '0;
			pulse_out <= 1'b0;
		end else begin
			phase_q <= wrap ? phase_sum - axis_pkg::CLK_HZ : phase_sum;
			pulse_out <= wrap;
		end
	end
endmodule : pulse_gen

// ---- src/axis_ctrl.sv ----
// Purpose: One positioning axis: JOG, absolute position restore and stop, APB registers
// Assumes: Servo handshake pins synchronous to pclk; APB master per AMBA
// Notes: Zero-wait APB slave; command bits are levels, starts act on rising edges
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module axis_ctrl #(
	parameter int unsigned ABS_TIMEOUT_CYC = axis_pkg::ABS_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pulse train to the amplifier
	output logic pulse_out,
	output logic dir_out,
	// Restore handshake from the amplifier
	input wire logic [1:0] abs_data_in,
	input wire logic abs_ready_in,
	// Restore handshake to the amplifier
	output logic servo_on_out,
	output logic abs_mode_out,
	output logic abs_req_out,
	// Axis flags
	output logic axis_busy_flag,
	output logic positioning_done_flag,
	output logic axis_error_flag,
	output logic operation_error_flag
);
	// Software registers
	logic [axis_pkg::CTL_W-1:0] ctrl_q; // Command and config bits
	logic [31:0] jog_speed_q; // JOG speed word pair
	logic [15:0] jog_acc_q; // JOG accel time, ms
	logic [15:0] jog_dec_q; // JOG decel time, ms
	logic [31:0] speed_limit_q; // Configured speed limit
	logic [15:0] op_err_code_q; // Operation error code
	logic [15:0] axis_err_code_q; // Axis error code
	logic [31:0] feed_q; // Current feed value
	// Flags and history
	logic busy_q;
	logic done_q;
	logic axerr_q;
	logic operr_q;
	logic stopped_q; // Last motion ended by stop
	logic dir_q; // Direction latched at start
	logic servo_q; // Servo on held after restore
	logic jog_prev_q;
	logic abs_prev_q;
	logic stop_prev_q;
	// Restore shifter
	logic [31:0] abs_shift_q;
	logic [3:0] abs_cnt_q;
	logic [31:0] timer_q; // Handshake timeout
	logic [31:0] prdata_q;
	axis_pkg::axis_state_t state_q;
	axis_pkg::axis_state_t state_d;

	motion_if m ();

	// Speed ramp and pulse generator
	speed_ramp u_ramp (
		.pclk(pclk),
		.presetn(presetn),
		.m(m.ramp)
	);
	pulse_gen u_gen (
		.pclk(pclk),
		.presetn(presetn),
		.m(m.gen),
		.pulse_out(pulse_out)
	);

	// APB decode
	wire setup_ph = psel && !penable;
	wire wr_en = psel && penable && pwrite;
	wire hit_ctrl = paddr == axis_pkg::OFS_CTRL;
	wire hit_speed = paddr == axis_pkg::OFS_JOG_SPEED;
	wire hit_acc = paddr == axis_pkg::OFS_JOG_ACC;
	wire hit_dec = paddr == axis_pkg::OFS_JOG_DEC;
	wire hit_flags = paddr == axis_pkg::OFS_FLAGS;
	wire hit_operr = paddr == axis_pkg::OFS_OP_ERR_CODE;
	wire hit_axerr = paddr == axis_pkg::OFS_AXIS_ERR_CODE;
	wire hit_status = paddr == axis_pkg::OFS_AXIS_STATUS;
	wire hit_feed = paddr == axis_pkg::OFS_FEED;
	wire hit_limit = paddr == axis_pkg::OFS_SPEED_LIMIT;
	wire hit_cur = paddr == axis_pkg::OFS_CUR_SPEED;
	wire mapped = hit_ctrl | hit_speed | hit_acc | hit_dec | hit_flags | hit_operr | hit_axerr
		| hit_status | hit_feed | hit_limit | hit_cur;
	// Write-one-to-clear of the two error flags
	wire clr_axerr = wr_en && hit_flags && pwdata[axis_pkg::FLG_AXERR];
	wire clr_operr = wr_en && hit_flags && pwdata[axis_pkg::FLG_OPERR];

	// Command edges; levels stay readable in ctrl_q
	wire enabled = ctrl_q[axis_pkg::CTL_ENABLE];
	wire stop_lvl = ctrl_q[axis_pkg::CTL_STOP];
	wire jog_lvl = ctrl_q[axis_pkg::CTL_JOG];
	wire jog_rise = jog_lvl && !jog_prev_q;
	wire abs_rise = ctrl_q[axis_pkg::CTL_ABS] && !abs_prev_q;
	wire stop_rise = stop_lvl && !stop_prev_q;
	wire idle = state_q == axis_pkg::S_IDLE;
	// A second start while busy is simply ignored
	wire start_try = (jog_rise || abs_rise) && idle;
	wire cmd_any = jog_rise || abs_rise || stop_rise;
	wire no_use = cmd_any && !enabled;
	wire bad_operand = start_try && enabled && ctrl_q[axis_pkg::CTL_OPBAD];
	wire stop_block = start_try && enabled && !ctrl_q[axis_pkg::CTL_OPBAD] && stop_lvl;
	wire time_bad = (jog_acc_q > axis_pkg::RAMP_MS_MAX) || (jog_dec_q > axis_pkg::RAMP_MS_MAX);
	wire range_bad = start_try && jog_rise && enabled && !ctrl_q[axis_pkg::CTL_OPBAD]
		&& !stop_lvl && time_bad;
	wire start_ok = start_try && enabled && !ctrl_q[axis_pkg::CTL_OPBAD] && !stop_lvl
		&& !(jog_rise && time_bad);
	wire jog_go = start_ok && jog_rise;
	wire abs_go = start_ok && !jog_rise;

	// Speed clamp: a set value above range runs at the limit
	wire [31:0] jog_speed_eff = (jog_speed_q > axis_pkg::JOG_SPEED_MAX) ? speed_limit_q : jog_speed_q;

	// Restore handshake status
	wire in_abs = (state_q == axis_pkg::S_ABS_REQ) || (state_q == axis_pkg::S_ABS_REL);
	wire abs_timeout = in_abs && (timer_q >= ABS_TIMEOUT_CYC);
	wire abs_take = (state_q == axis_pkg::S_ABS_REQ) && abs_ready_in;
	wire abs_finish = (state_q == axis_pkg::S_ABS_REL) && !abs_ready_in
		&& (abs_cnt_q == axis_pkg::ABS_LAST_XFER);
	wire ramp_zero = m.speed == 32'h00000000;
	wire stop_done = (state_q == axis_pkg::S_STOP_DEC) && ramp_zero;

	// Stop acts only while running a JOG; JOG deceleration and restore ignore it
	wire stop_act = stop_lvl && enabled && (state_q == axis_pkg::S_JOG_RUN);

	// Axis operation status as seen by software
	logic [15:0] axis_status;
	always_comb begin
		unique case (state_q)
			axis_pkg::S_IDLE: axis_status = axerr_q ? axis_pkg::ST_ERROR
				: (stopped_q ? axis_pkg::ST_STOPPED : axis_pkg::ST_STANDBY);
			axis_pkg::S_JOG_RUN: axis_status = axis_pkg::ST_JOG_RUN;
			axis_pkg::S_JOG_DEC: axis_status = axis_pkg::ST_JOG_DEC;
			axis_pkg::S_STOP_DEC: axis_status = axis_pkg::ST_STOP_DEC;
			axis_pkg::S_ABS_REQ, axis_pkg::S_ABS_REL: axis_status = axis_pkg::ST_ABS;
			default: axis_status = axis_pkg::ST_ERROR;
		endcase
	end

	// Ramp command: accelerate while running, decelerate otherwise
	assign m.target = (state_q == axis_pkg::S_JOG_RUN) ? jog_speed_eff : 32'h00000000;
	assign m.ref_speed = jog_speed_eff;
	assign m.ramp_ms = (state_q == axis_pkg::S_JOG_RUN) ? jog_acc_q : jog_dec_q;

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			axis_pkg::S_IDLE: begin
				if (jog_go) begin
					state_d = axis_pkg::S_JOG_RUN;
				end else if (abs_go) begin
					state_d = axis_pkg::S_ABS_REQ;
				end
			end
			axis_pkg::S_JOG_RUN: begin
				if (stop_act) begin
					state_d = axis_pkg::S_STOP_DEC;
				end else if (!jog_lvl) begin
					state_d = axis_pkg::S_JOG_DEC;
				end
			end
			axis_pkg::S_JOG_DEC: begin
				if (ramp_zero) begin
					state_d = axis_pkg::S_IDLE;
				end
			end
			axis_pkg::S_STOP_DEC: begin
				if (ramp_zero) begin
					state_d = axis_pkg::S_IDLE;
				end
			end
			axis_pkg::S_ABS_REQ: begin
				if (abs_timeout) begin
					state_d = axis_pkg::S_IDLE;
				end else if (abs_ready_in) begin
					state_d = axis_pkg::S_ABS_REL;
				end
			end
			axis_pkg::S_ABS_REL: begin
				if (abs_timeout || abs_finish) begin
					state_d = axis_pkg::S_IDLE;
				end else if (!abs_ready_in) begin
					state_d = axis_pkg::S_ABS_REQ;
				end
			end
			default: state_d = axis_pkg::S_IDLE;
		endcase
	end

	// Sequencer and command history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= axis_pkg::S_IDLE;
			jog_prev_q <= 1'b0;
			abs_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			jog_prev_q <= jog_lvl;
			abs_prev_q <= ctrl_q[axis_pkg::CTL_ABS];
			stop_prev_q <= stop_lvl;
		end
	end

	// Busy follows the sequencer; done only on restore success
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			stopped_q <= 1'b0;
		end else begin
			busy_q <= state_d != axis_pkg::S_IDLE;
			if (abs_finish && !abs_timeout) begin
				done_q <= 1'b1;
			end else if (start_ok) begin
				done_q <= 1'b0;
			end
			if (stop_done) begin
				stopped_q <= 1'b1;
			end else if (start_ok) begin
				stopped_q <= 1'b0;
			end
		end
	end

	// Error flags: a new error wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			axerr_q <= 1'b0;
			operr_q <= 1'b0;
			axis_err_code_q <= 16'h0000;
			op_err_code_q <= 16'h0000;
		end else begin
			if (stop_block) begin
				axerr_q <= 1'b1;
				axis_err_code_q <= axis_pkg::AXERR_STOP_AT_START;
			end else if (range_bad) begin
				axerr_q <= 1'b1;
				axis_err_code_q <= axis_pkg::AXERR_DATA_RANGE;
			end else if (abs_timeout) begin
				axerr_q <= 1'b1;
				axis_err_code_q <= axis_pkg::AXERR_ABS_TIMEOUT;
			end else if (clr_axerr) begin
				axerr_q <= 1'b0;
			end
			if (no_use) begin
				operr_q <= 1'b1;
				op_err_code_q <= axis_pkg::OPERR_NOT_USED;
			end else if (bad_operand) begin
				operr_q <= 1'b1;
				op_err_code_q <= axis_pkg::OPERR_OPERAND;
			end else if (clr_operr) begin
				operr_q <= 1'b0;
			end
		end
	end

	// Direction latched at start so a mid-run write cannot reverse the axis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q <= 1'b0;
		end else if (jog_go) begin
			dir_q <= ctrl_q[axis_pkg::CTL_DIR];
		end
	end

	// Restore handshake: two bits per transfer, least significant pair first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abs_shift_q <= '0;
			abs_cnt_q <= 4'h0;
			timer_q <= '0;
			servo_q <= 1'b0;
		end else begin
			if (abs_go) begin
				abs_cnt_q <= 4'h0;
				servo_q <= 1'b1;
			end else if (abs_timeout) begin
				servo_q <= 1'b0;
			end else if ((state_q == axis_pkg::S_ABS_REL) && !abs_ready_in) begin
				abs_cnt_q <= abs_cnt_q + 4'h1;
			end
			if (abs_take) begin
				abs_shift_q <= {abs_data_in, abs_shift_q[31:2]};
			end
			// Timeout restarts on every handshake phase change
			timer_q <= (state_d != state_q || !in_abs) ? 32'h00000000 : timer_q + 32'h00000001;
		end
	end

	// Feed value: counts pulses, or takes the restored position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feed_q <= '0;
		end else if (abs_finish && !abs_timeout) begin
			feed_q <= abs_shift_q;
		end else if (m.step) begin
			feed_q <= dir_q ? feed_q - 32'h00000001 : feed_q + 32'h00000001;
		end
	end

	// Register writes on the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
			jog_speed_q <= '0;
			jog_acc_q <= 16'h0000;
			jog_dec_q <= 16'h0000;
			speed_limit_q <= axis_pkg::SPEED_LIMIT_RST;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				ctrl_q <= pwdata[axis_pkg::CTL_W-1:0];
			end
			if (hit_speed) begin
				jog_speed_q <= pwdata;
			end
			if (hit_acc) begin
				jog_acc_q <= pwdata[15:0];
			end
			if (hit_dec) begin
				jog_dec_q <= pwdata[15:0];
			end
			if (hit_limit) begin
				speed_limit_q <= pwdata;
			end
		end
	end

	// Read mux, captured during setup so read data comes from a flop
	wire [31:0] flags_rd = {27'h0, servo_q, operr_q, axerr_q, done_q, busy_q};
	wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_q}
		: hit_speed ? jog_speed_q
		: hit_acc ? {16'h0000, jog_acc_q}
		: hit_dec ? {16'h0000, jog_dec_q}
		: hit_flags ? flags_rd
		: hit_operr ? {16'h0000, op_err_code_q}
		: hit_axerr ? {16'h0000, axis_err_code_q}
		: hit_status ? {{16{axis_status[15]}}, axis_status}
		: hit_feed ? feed_q
		: hit_limit ? speed_limit_q
		: hit_cur ? m.speed
		: 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (setup_ph) begin
			prdata_q <= rd_mux;
		end
	end

	// Bus answers: no wait states, error on unmapped address
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Pins and flags
	assign dir_out = dir_q;
	assign servo_on_out = servo_q;
	assign abs_mode_out = in_abs;
	assign abs_req_out = state_q == axis_pkg::S_ABS_REQ;
	assign axis_busy_flag = busy_q;
	assign positioning_done_flag = done_q;
	assign axis_error_flag = axerr_q;
	assign operation_error_flag = operr_q;
endmodule : axis_ctrl

// ---- dv/axis_ctrl_props.sv ----
// Purpose: Port-level checks of the axis block
// Assumes: Single pclk domain, presetn active low
// Notes: Watches only design outputs and the ready input
`timescale 1ns/1ps
module axis_ctrl_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Motion pins
	input wire logic pulse_out,
	input wire logic dir_out,
	// Restore link
	input wire logic abs_ready_in,
	input wire logic servo_on_out,
	input wire logic abs_mode_out,
	input wire logic abs_req_out,
	// Flags
	input wire logic axis_busy_flag,
	input wire logic positioning_done_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Request only inside a restore
	chk_req_in_mode: assert property (abs_req_out |-> abs_mode_out)
		else $error("restore request outside restore");
	// Amplifier powered while asking for data
	chk_servo_on_req: assert property (abs_req_out |-> servo_on_out)
		else $error("servo off during request");
	// Restore always counts as busy
	chk_busy_restore: assert property (abs_mode_out |-> axis_busy_flag)
		else $error("restore without busy");
	// Request drops early only on timeout
	chk_req_after_rdy: assert property ($fell(abs_req_out) && abs_mode_out |-> $past(abs_ready_in))
		else $error("request dropped before ready");
	// Only a finished restore may raise done
	chk_done_source: assert property ($rose(positioning_done_flag) |-> $past(abs_mode_out) && !axis_busy_flag)
		else $error("done raised outside restore end");
	// A new start wipes done within a cycle
	chk_start_clr_done: assert property ($rose(axis_busy_flag) |-> ##[0:1] !positioning_done_flag)
		else $error("done kept after start");
	// Steps only while the axis runs
	chk_pulse_busy: assert property (pulse_out |-> axis_busy_flag || $past(axis_busy_flag))
		else $error("pulse while idle");
	// Direction frozen during a move
	chk_dir_stable: assert property (axis_busy_flag && $past(axis_busy_flag) |-> $stable(dir_out))
		else $error("direction changed in motion");
endmodule : axis_ctrl_props

// ---- dv/servo_amp_model.sv ----
// Purpose: Amplifier side of the restore handshake
// Assumes: Two bits per transfer, low pair first
// Notes: mute never answers; dly sets reply latency
`timescale 1ns/1ps
module servo_amp_model #(
	parameter logic [31:0] POS = 32'hA5C31E69
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic abs_req_out,
	input wire logic abs_mode_out,
	input wire logic mute,
	input wire logic [3:0] dly,
	output logic [1:0] abs_data_in,
	output logic abs_ready_in
);
	logic [3:0] idx_q; // Transfer index
	logic [3:0] wt_q; // Latency counter
	// Answer request, release, step; data inverts when not valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q <= 4'h0;
			wt_q <= 4'h0;
			abs_ready_in <= 1'b0;
			abs_data_in <= 2'h3;
		end else begin
			if (!abs_mode_out)
				idx_q <= 4'h0;
			if (abs_req_out && !abs_ready_in && !mute) begin
				wt_q <= (wt_q == dly) ? 4'h0 : wt_q + 4'h1;
				if (wt_q == dly) begin
					abs_ready_in <= 1'b1;
					abs_data_in <= POS[{idx_q, 1'b0} +: 2];
				end
			end else if (!abs_req_out && abs_ready_in) begin
				wt_q <= (wt_q == dly) ? 4'h0 : wt_q + 4'h1;
				if (wt_q == dly) begin
					abs_ready_in <= 1'b0;
					abs_data_in <= ~abs_data_in;
					idx_q <= idx_q + 4'h1;
				end
			end
		end
	end
endmodule : servo_amp_model

// ---- dv/axis_jog_abs_restore_stop_bench.sv ----
// Purpose: Self-checking bench of the axis block over APB
// Assumes: Zero-wait slave, short restore timeout
// Notes: Stop held until the move ends, not a full 2 ms
`timescale 1ns/1ps
module axis_jog_abs_restore_stop_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, mute;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pulse_out, dir_out, abs_ready_in, servo_on_out, abs_mode_out, abs_req_out;
	logic axis_busy_flag, positioning_done_flag, axis_error_flag, operation_error_flag;
	logic [1:0] abs_data_in;
	logic [3:0] dly;
	int fail_count = 0;
	int check_count = 0;
	int n;
	localparam logic [31:0] EN = 32'h00000001; // Axis enabled
	localparam logic [31:0] DR = 32'h00000002; // Reverse
	localparam logic [31:0] JG = 32'h00000004; // JOG level
	localparam logic [31:0] AB = 32'h00000008; // Restore
	localparam logic [31:0] SP = 32'h00000010; // Stop level
	localparam logic [31:0] BD = 32'h00000020; // Bad operand
	axis_ctrl #(.ABS_TIMEOUT_CYC(200)) u_axis_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pulse_out(pulse_out), .dir_out(dir_out),
		.abs_data_in(abs_data_in), .abs_ready_in(abs_ready_in), .servo_on_out(servo_on_out),
		.abs_mode_out(abs_mode_out), .abs_req_out(abs_req_out), .axis_busy_flag(axis_busy_flag),
		.positioning_done_flag(positioning_done_flag), .axis_error_flag(axis_error_flag),
		.operation_error_flag(operation_error_flag));
	servo_amp_model u_servo_amp_model (.pclk(pclk), .presetn(presetn), .abs_req_out(abs_req_out),
		.abs_mode_out(abs_mode_out), .mute(mute), .dly(dly), .abs_data_in(abs_data_in),
		.abs_ready_in(abs_ready_in));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer, then one idle cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : acc
	// Bounded wait for busy level, sampled mid-cycle where it has settled
	task automatic wb(input logic e, input int lim);
		@(negedge pclk);
		for (int i = 0; i < lim && axis_busy_flag !== e; i++)
			@(negedge pclk);
		chk("busy", {31'h0, axis_busy_flag}, {31'h0, e});
		@(posedge pclk);
	endtask : wb
	// Refused start: expected code and flags
	task automatic er(input logic [31:0] c, input logic [7:0] a, input logic [31:0] x, input logic [31:0] f);
		acc(1'b1, axis_pkg::OFS_CTRL, c & ~JG);
		acc(1'b1, axis_pkg::OFS_CTRL, c);
		acc(0, a, 0);
		chk("code", rd, x);
		acc(0, axis_pkg::OFS_FLAGS, 0);
		chk("flags", rd & 32'h0000000F, f);
		chk("operr pin", {31'h0, operation_error_flag}, {31'h0, f[3]});
		acc(1'b1, axis_pkg::OFS_FLAGS, 32'h0000000C);
	endtask : er
	task automatic end_sim;
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard
	initial begin
		#500us;
		fail_count++;
		end_sim();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, presetn, mute} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		dly = 4'h1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(0, axis_pkg::OFS_SPEED_LIMIT, 0);
		chk("limit", rd, 32'h00030D40);
		acc(0, 8'h2C, 0);
		chk("unmapped", {rd[30:0], se}, 32'h00000001);
		er(JG, axis_pkg::OFS_OP_ERR_CODE, 32'h00001014, 32'h00000008);
		er(EN | BD | JG, axis_pkg::OFS_OP_ERR_CODE, 32'h00001005, 32'h00000008);
		er(EN | SP | JG, axis_pkg::OFS_AXIS_ERR_CODE, 32'h0000044E, 32'h00000004);
		acc(1'b1, axis_pkg::OFS_JOG_ACC, 32'h00008000);
		er(EN | JG, axis_pkg::OFS_AXIS_ERR_CODE, 32'h000003E8, 32'h00000004);
		acc(1'b1, axis_pkg::OFS_JOG_ACC, 0);
		acc(1'b1, axis_pkg::OFS_JOG_SPEED, 32'h00030D40);
		// Both directions, run while held, end on release
		for (int d = 0; d < 2; d++) begin
			acc(1'b1, axis_pkg::OFS_CTRL, EN | (d ? DR : 0));
			acc(1'b1, axis_pkg::OFS_CTRL, EN | JG | (d ? DR : 0));
			wb(1, 10);
			chk("dir", {31'h0, dir_out}, d);
			n = 0;
			repeat (1500) @(posedge pclk) n += pulse_out;
			chk("pulses", n > 1, 1);
			acc(1'b1, axis_pkg::OFS_CTRL, EN | (d ? DR : 0));
			wb(0, 50);
			chk("done", {31'h0, positioning_done_flag}, 0);
		end
		acc(1'b1, axis_pkg::OFS_SPEED_LIMIT, 32'h000186A0);
		acc(1'b1, axis_pkg::OFS_JOG_SPEED, 32'h00FFFFFF);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | JG);
		wb(1, 10);
		acc(0, axis_pkg::OFS_CUR_SPEED, 0);
		chk("speed", rd, 32'h000186A0);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | JG | SP);
		wb(0, 50);
		acc(0, axis_pkg::OFS_AXIS_STATUS, 0);
		chk("status", rd, 32'h00000001);
		chk("done", {31'h0, positioning_done_flag}, 0);
		acc(1'b1, axis_pkg::OFS_CTRL, EN);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | SP);
		repeat (5) @(posedge pclk);
		chk("idle stop", {30'h0, axis_busy_flag, axis_error_flag}, 0);
		acc(0, axis_pkg::OFS_AXIS_STATUS, 0);
		chk("idle status", rd, 32'h00000001);
		// Restore with a stop raised midway
		dly = 4'h3;
		acc(1'b1, axis_pkg::OFS_CTRL, EN);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | AB);
		wb(1, 10);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | AB | SP);
		chk("servo", {31'h0, servo_on_out}, 1);
		wb(0, 2000);
		chk("done", {31'h0, positioning_done_flag}, 1);
		acc(0, axis_pkg::OFS_FEED, 0);
		chk("feed", rd, 32'hA5C31E69);
		acc(1'b1, axis_pkg::OFS_JOG_ACC, 32'h00000001);
		acc(1'b1, axis_pkg::OFS_CTRL, EN);
		acc(1'b1, axis_pkg::OFS_CTRL, EN | JG);
		wb(1, 10);
		chk("done", {31'h0, positioning_done_flag}, 0);
		acc(0, axis_pkg::OFS_CUR_SPEED, 0);
		chk("ramp", rd != 0 && rd < 32'h00000100, 1);
		acc(1'b1, axis_pkg::OFS_CTRL, EN);
		wb(0, 50);
		// Silent amplifier times out
		mute <= 1'b1;
		acc(1'b1, axis_pkg::OFS_CTRL, EN | AB);
		wb(1, 10);
		wb(0, 800);
		chk("done", {31'h0, positioning_done_flag}, 0);
		acc(0, axis_pkg::OFS_AXIS_ERR_CODE, 0);
		chk("timeout", rd, 32'h000007D0);
		end_sim();
	end
endmodule : axis_jog_abs_restore_stop_bench
bind axis_ctrl axis_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .pulse_out(pulse_out),
	.dir_out(dir_out), .abs_ready_in(abs_ready_in), .servo_on_out(servo_on_out),
	.abs_mode_out(abs_mode_out), .abs_req_out(abs_req_out), .axis_busy_flag(axis_busy_flag),
	.positioning_done_flag(positioning_done_flag));
